// ---- logic/fpe_flash_protect.sv ----
// flash error status, erase-block select and ram overlay control block with axi4-lite slave
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - programming error sets sticky flag, protects flash
// - error flag cleared only by reset/hw standby
// - status read-only, low seven bits zero
// - rom-disabled modes: status and selects read zero, select and overlay writes ignored
// - select registers cleared by resets, standby, write-enable
// - set select bit allows erase of block
// - more than one select bit clears both
// - high select upper nibble reads zero
// - twelve blocks with documented address map
// - overlay register reset, kept in soft standby
// - window select picks ram 8000 or A000
// - overlay enable protects all flash blocks
// - block code picks overlaid 4 kB block
// - overlay bits ignored in rom-disabled modes
// - select writes need write-enable bit set
module fpe_flash_protect (
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // device state inputs
   input  wire logic        hw_standby,
   input  wire logic        sw_standby,
   input  wire logic        rom_disabled,
   input  wire logic        write_enable_pin,
   input  wire logic        soft_write_enable,
   input  wire logic        flash_error_event,
   // cpu flash address translation
   input  wire logic [31:0] cpu_addr,
   output logic [31:0]      mapped_addr,
   output logic             mapped_to_ram,
   // protection outputs to the flash sequencer, and interrupt request
   output logic [fpe_pkg::NUM_BLOCKS-1:0] erase_allow,
   output logic             prog_erase_protect,
   output logic             irq
);
   import fpe_pkg::*;

   // ==============================================================
   // helpers
   // true when more than one bit of the twelve is set
   function automatic logic multi_hot(input logic [NUM_BLOCKS-1:0] v);
      multi_hot = (v & (v - 12'h001)) != 12'h000;
   endfunction

   // byte-lane merge of a register byte
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
      lane0 = s[0] ? d[7:0] : old;
   endfunction

   // ==============================================================
   // state
   logic                  err_flag;         // flash_error_flag
   logic [7:0]            ebs_low;          // erase_block_select_low
   logic [EBS_HIGH_W-1:0] ebs_high;         // writable nibble of high select
   logic [OVL_W-1:0]      ovl;              // ram_overlay_control bits 4..0
   logic [IRQ_W-1:0]      irq_status;       // sticky events
   logic [IRQ_W-1:0]      irq_enable;       // event enables
   logic                  aw_held;          // write address captured
   logic                  w_held;           // write data captured
   logic [7:0]            aw_addr;          // captured write address
   logic [31:0]           w_data;           // captured write data
   logic [3:0]            w_strb;           // captured strobes
   logic                  next_err_flag;
   logic [7:0]            next_ebs_low;
   logic [EBS_HIGH_W-1:0] next_ebs_high;
   logic [OVL_W-1:0]      next_ovl;
   logic [IRQ_W-1:0]      next_irq_status;
   logic [IRQ_W-1:0]      next_irq_enable;
   logic                  next_aw_held;
   logic                  next_w_held;
   logic [7:0]            next_aw_addr;
   logic [31:0]           next_w_data;
   logic [3:0]            next_w_strb;
   logic                  next_awready;
   logic                  next_wready;
   logic                  next_bvalid;
   logic [1:0]            next_bresp;
   logic                  next_arready;
   logic                  next_rvalid;
   logic [31:0]           next_rdata;
   logic [1:0]            next_rresp;
   logic [31:0]           next_mapped_addr;
   logic                  next_mapped_to_ram;
   logic [NUM_BLOCKS-1:0] next_erase_allow;
   logic                  next_protect;
   logic                  next_irq;
   // decoded helpers
   logic                  do_write;         // both halves of a write held
   logic                  sel_clear;        // forced clear of erase selects
   logic                  ovl_active;       // overlay effective
   logic [NUM_BLOCKS-1:0] sel_all;          // candidate select vector
   logic [IRQ_W-1:0]      events;           // this cycle's events

   // ==============================================================
   // write channel and register next state
   always_comb begin
      next_aw_held    = aw_held;
      next_w_held     = w_held;
      next_aw_addr    = aw_addr;
      next_w_data     = w_data;
      next_w_strb     = w_strb;
      next_bvalid     = s_axi_bvalid;
      next_bresp      = s_axi_bresp;
      next_err_flag   = err_flag;
      next_ebs_low    = ebs_low;
      next_ebs_high   = ebs_high;
      next_ovl        = ovl;
      next_irq_enable = irq_enable;
      events          = '0;
      // address and data may come in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      do_write = aw_held && w_held && !s_axi_bvalid;
      sel_all  = {ebs_high, ebs_low};
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         case (aw_addr)
            ADDR_ERR_STATUS: ;                             // read-only, write dropped
            ADDR_EBS_LOW: begin
               // writes need the write-enable mirror and a rom-enabled mode
               if (write_enable_pin && !rom_disabled) begin
                  sel_all[7:0] = lane0(ebs_low, w_data, w_strb);
               end
            end
            ADDR_EBS_HIGH: begin
               if (write_enable_pin && !rom_disabled && w_strb[0]) begin
                  sel_all[11:8] = w_data[EBS_HIGH_W-1:0];  // upper nibble not stored
               end
            end
            ADDR_OVL_CTRL: begin
               if (!rom_disabled && w_strb[0]) begin
                  next_ovl  = w_data[OVL_W-1:0];
                  events[EV_OVL] = 1'b1;
               end
            end
            ADDR_IRQ_ENABLE: begin
               if (w_strb[0]) begin
                  next_irq_enable = w_data[IRQ_W-1:0];
               end
            end
            ADDR_IRQ_CLEAR, ADDR_IRQ_STATUS, ADDR_CTRL_STATUS: ;
            default: next_bresp = RESP_SLVERR;             // unmapped address
         endcase
      end
      // more than one block selected clears both registers
      if (multi_hot(sel_all)) begin
         sel_all = '0;
         events[EV_MULTI] = 1'b1;
      end
      next_ebs_low  = sel_all[7:0];
      next_ebs_high = sel_all[11:8];
      // standby and write-enable conditions force the selects clear
      sel_clear = hw_standby || sw_standby || !write_enable_pin || !soft_write_enable;
      if (sel_clear) begin
         next_ebs_low  = EBS_RESET;
         next_ebs_high = EBS_RESET[EBS_HIGH_W-1:0];
      end
      // sticky error flag, cleared only by hardware standby here
      if (flash_error_event && !err_flag) begin
         events[EV_ERROR] = 1'b1;
      end
      if (flash_error_event) begin
         next_err_flag = 1'b1;
      end
      if (hw_standby) begin
         next_err_flag = 1'b0;
         next_ovl      = OVL_RESET;                        // kept in soft standby
      end
   end

   // ==============================================================
   // interrupt status: set wins over clear
   always_comb begin
      next_irq_status = irq_status;
      if (do_write && aw_addr == ADDR_IRQ_CLEAR && w_strb[0]) begin
         next_irq_status = next_irq_status & ~w_data[IRQ_W-1:0];
      end
      next_irq_status = next_irq_status | events;
      next_irq        = |(next_irq_status & next_irq_enable);
   end

   // ==============================================================
   // read channel
   always_comb begin
      next_arready = 1'b0;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
         next_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            // flag in bit 7, bits 6..0 read zero; zero in rom-disabled modes
            ADDR_ERR_STATUS:  next_rdata[ERR_FLAG_BIT] = err_flag && !rom_disabled;
            ADDR_EBS_LOW:     next_rdata[7:0] = rom_disabled ? 8'h00 : ebs_low;
            ADDR_EBS_HIGH:    next_rdata[EBS_HIGH_W-1:0] = rom_disabled ? 4'h0 : ebs_high;
            ADDR_OVL_CTRL:    next_rdata[OVL_W-1:0] = ovl;
            ADDR_IRQ_STATUS:  next_rdata[IRQ_W-1:0] = irq_status;
            ADDR_IRQ_ENABLE:  next_rdata[IRQ_W-1:0] = irq_enable;
            ADDR_IRQ_CLEAR:   next_rdata = 32'h0000_0000;
            ADDR_CTRL_STATUS: next_rdata[4:0] = {prog_erase_protect, rom_disabled, sw_standby,
                                                 soft_write_enable, write_enable_pin};
            default:          next_rresp = RESP_SLVERR;
         endcase
      end
   end

   // ==============================================================
   // protection and overlay address translation
   always_comb begin
      // overlay bits are ignored with on-chip rom disabled
      ovl_active = ovl[OVL_EN_BIT] && !rom_disabled;
      // error flag or overlay protects every block
      next_protect     = err_flag || ovl_active;
      // each set select bit opens its block for erase
      next_erase_allow = next_protect ? '0 : {next_ebs_high, next_ebs_low};
      next_mapped_addr   = cpu_addr;
      next_mapped_to_ram = 1'b0;
      // block n of the 4 kB area is n*0x1000
      if (ovl_active && cpu_addr < BLK8_BASE &&
          cpu_addr[14:12] == ovl[2:0]) begin
         // same offset inside the chosen window
         next_mapped_addr   = (ovl[OVL_WIN_BIT] ? RAM_WIN1_BASE : RAM_WIN0_BASE) |
                              (cpu_addr & (BLK_SMALL_SIZE - 32'h1));
         next_mapped_to_ram = 1'b1;
      end
   end

   // ==============================================================
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_flag           <= 1'b0;
         ebs_low            <= EBS_RESET;
         ebs_high           <= '0;
         ovl                <= OVL_RESET;
         irq_status         <= IRQ_RESET;
         irq_enable         <= IRQ_RESET;
         aw_held            <= 1'b0;
         w_held             <= 1'b0;
         aw_addr            <= 8'h00;
         w_data             <= 32'h0000_0000;
         w_strb             <= 4'h0;
         s_axi_bvalid       <= 1'b0;
         s_axi_bresp        <= RESP_OKAY;
         s_axi_arready      <= 1'b0;
         s_axi_rvalid       <= 1'b0;
         s_axi_rdata        <= 32'h0000_0000;
         s_axi_rresp        <= RESP_OKAY;
         mapped_addr        <= 32'h0000_0000;
         mapped_to_ram      <= 1'b0;
         erase_allow        <= '0;
         prog_erase_protect <= 1'b0;
         irq                <= 1'b0;
      end else if (clk_en) begin
         err_flag           <= next_err_flag;
         ebs_low            <= next_ebs_low;
         ebs_high           <= next_ebs_high;
         ovl                <= next_ovl;
         irq_status         <= next_irq_status;
         irq_enable         <= next_irq_enable;
         aw_held            <= next_aw_held;
         w_held             <= next_w_held;
         aw_addr            <= next_aw_addr;
         w_data             <= next_w_data;
         w_strb             <= next_w_strb;
         s_axi_bvalid       <= next_bvalid;
         s_axi_bresp        <= next_bresp;
         s_axi_arready      <= next_arready;
         s_axi_rvalid       <= next_rvalid;
         s_axi_rdata        <= next_rdata;
         s_axi_rresp        <= next_rresp;
         mapped_addr        <= next_mapped_addr;
         mapped_to_ram      <= next_mapped_to_ram;
         erase_allow        <= next_erase_allow;
         prog_erase_protect <= next_protect;
         irq                <= next_irq;
      end
   end

   // ready registers for aw/w: taken one cycle after valid, one at a time
   always_comb begin
      next_awready = !aw_held && !s_axi_awready && s_axi_awvalid;
      next_wready  = !w_held && !s_axi_wready && s_axi_wvalid;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else if (clk_en) begin
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
      end
   end

   // ==============================================================
   // assertions
   property p_err_sticky;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && err_flag && !hw_standby) |=> err_flag;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

   property p_err_set;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && flash_error_event && !hw_standby) |=> err_flag ##1 (!clk_en || prog_erase_protect);
   endproperty
   a_err_set: assert property (p_err_set) else $error("error not protecting");

   property p_one_hot;
      @(posedge aclk) disable iff (!aresetn)
      !multi_hot({ebs_high, ebs_low});
   endproperty
   a_one_hot: assert property (p_one_hot) else $error("multiple selects");

   property p_sel_clear;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && (sw_standby || !write_enable_pin || !soft_write_enable)) |=> ({ebs_high, ebs_low} == 12'h000);
   endproperty
   a_sel_clear: assert property (p_sel_clear) else $error("selects not cleared");

   property p_status_read;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && $rose(s_axi_rvalid) && s_axi_rresp == RESP_OKAY |-> (s_axi_rdata[6:0] == 7'h00 ||
         $past(s_axi_araddr) != ADDR_ERR_STATUS);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status low bits");
   property p_overlay_protect;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && ovl[OVL_EN_BIT] && !rom_disabled) |=> (!clk_en || (prog_erase_protect && erase_allow == '0));
   endproperty
   a_overlay_protect: assert property (p_overlay_protect) else $error("overlay not protecting");

   property p_redirect;
      @(posedge aclk) disable iff (!aresetn)
      mapped_to_ram |-> (mapped_addr[31:13] == 19'h7FFFC || mapped_addr[31:12] == 20'hFFFFA);
   endproperty
   a_redirect: assert property (p_redirect) else $error("bad ram window");

   property p_rom_off_map;
      @(posedge aclk) disable iff (!aresetn)
      (clk_en && rom_disabled && !err_flag) |=> (!clk_en || !mapped_to_ram);
   endproperty
   a_rom_off_map: assert property (p_rom_off_map) else $error("overlay active rom off");

   c_write_resp: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
   c_redirect:   cover property (@(posedge aclk) disable iff (!aresetn) mapped_to_ram);
   c_error:      cover property (@(posedge aclk) disable iff (!aresetn) $rose(err_flag));
   c_irq:        cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule

// ---- logic/fpe_pkg.sv ----
// package: register map, field layout and address constants for flash protect / overlay block
package fpe_pkg;
   // ==============================================================
   // register byte addresses (axi4-lite, one aligned word each)
   localparam logic [7:0]  ADDR_ERR_STATUS   = 8'h00;  // flash_error_status
   localparam logic [7:0]  ADDR_EBS_LOW      = 8'h04;  // erase_block_select_low
   localparam logic [7:0]  ADDR_EBS_HIGH     = 8'h08;  // erase_block_select_high
   localparam logic [7:0]  ADDR_OVL_CTRL     = 8'h0C;  // ram_overlay_control
   localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h10;  // sticky event status (ro)
   localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'h14;  // event enable
   localparam logic [7:0]  ADDR_IRQ_CLEAR    = 8'h18;  // write one to clear (wo)
   localparam logic [7:0]  ADDR_CTRL_STATUS  = 8'h1C;  // live pins / protect view (ro)
   // ==============================================================
   // field positions and widths
   localparam int          ERR_FLAG_BIT      = 7;      // flash_error_flag
   localparam int          EBS_HIGH_W        = 4;      // writable low nibble of high select
   localparam int          NUM_BLOCKS        = 12;     // erase blocks
   localparam int          OVL_W             = 5;      // writable overlay bits 4..0
   localparam int          OVL_WIN_BIT       = 4;      // overlay_window_select
   localparam int          OVL_EN_BIT        = 3;      // overlay_enable
   localparam int          IRQ_W             = 3;      // event bits
   localparam int          EV_ERROR          = 0;      // error flag rose
   localparam int          EV_MULTI          = 1;      // multi-select auto clear
   localparam int          EV_OVL            = 2;      // overlay control written
   // ==============================================================
   // reset values
   localparam logic [7:0]  EBS_RESET         = 8'h00;
   localparam logic [OVL_W-1:0] OVL_RESET    = 5'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET    = 3'h0;
   // ==============================================================
   // address map (rule figures)
   localparam logic [31:0] BLK_SMALL_SIZE    = 32'h0000_1000; // 4 kB blocks 0..7
   localparam logic [31:0] BLK8_BASE         = 32'h0000_8000; // 32 kB block 8
   localparam logic [31:0] BLK9_BASE         = 32'h0001_0000; // 64 kB blocks 9..11
   localparam logic [31:0] FLASH_TOP         = 32'h0004_0000; // end of flash
   localparam logic [31:0] RAM_WIN0_BASE     = 32'hFFFF_8000; // window select 0
   localparam logic [31:0] RAM_WIN1_BASE     = 32'hFFFF_A000; // window select 1
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

// ---- sim/tb_fpe_flash_protect.sv ----
// self-checking bench for the flash protect, erase select and overlay block
`timescale 1ns/1ps
module tb_fpe_flash_protect;
   import fpe_pkg::*;
   // ==============================================================
   // stimulus, all driven by the bench from time zero
   logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, cpu_addr = 32'h0, rdat;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, flash_error_event = 1'h0;
   logic        hw_standby = 1'h0, sw_standby = 1'h0, rom_disabled = 1'h0;
   logic        write_enable_pin = 1'h0, soft_write_enable = 1'h0;
   // design outputs
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
   logic [31:0] s_axi_rdata, mapped_addr;
   logic        mapped_to_ram, prog_erase_protect, irq;
   logic [NUM_BLOCKS-1:0] erase_allow;
   int          failures = 0, n_compared = 0;
   // 200 mhz clock
   always #2.5 aclk = ~aclk;
   fpe_flash_protect i_dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .hw_standby, .sw_standby, .rom_disabled, .write_enable_pin,
      .soft_write_enable, .flash_error_event, .cpu_addr, .mapped_addr, .mapped_to_ram,
      .erase_allow, .prog_erase_protect, .irq);
   // ==============================================================
   // shared helpers
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // write: offer address and data together, release each when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   // read and compare data and response code
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      chk(rdat, e);
      chk({30'h0, rrsp}, {30'h0, r});
   endtask
   // ==============================================================
   // scenarios
   task automatic t_reset;
      rd(ADDR_ERR_STATUS, 32'h0);
      rd(ADDR_EBS_LOW, 32'h0);
      rd(ADDR_EBS_HIGH, 32'h0);
      rd(ADDR_OVL_CTRL, 32'h0);
   endtask
   // error flag: sticky, ignores writes, only standby clears it; irq masked and cleared
   task automatic t_error;
      axw(ADDR_IRQ_ENABLE, 32'h1);
      @(posedge aclk) flash_error_event <= 1'h1;
      @(posedge aclk) flash_error_event <= 1'h0;
      cyc(3);
      rd(ADDR_ERR_STATUS, 32'h80);
      chk({31'h0, prog_erase_protect}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      axw(ADDR_ERR_STATUS, 32'h0);
      rd(ADDR_ERR_STATUS, 32'h80);
      axw(ADDR_IRQ_ENABLE, 32'h0);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      @(posedge aclk) hw_standby <= 1'h1;
      @(posedge aclk) hw_standby <= 1'h0;
      rd(ADDR_ERR_STATUS, 32'h0);
      chk({31'h0, prog_erase_protect}, 32'h0);
      axw(ADDR_IRQ_CLEAR, 32'h7);
      rd(ADDR_IRQ_STATUS, 32'h0);
   endtask
   // erase select: one bit, upper nibble reads zero, multi-select and enable clearing
   task automatic t_select;
      @(posedge aclk) write_enable_pin <= 1'h1;
      soft_write_enable <= 1'h1;
      axw(ADDR_EBS_LOW, 32'h04);
      rd(ADDR_EBS_LOW, 32'h04);
      chk({20'h0, erase_allow}, 32'h004);
      axw(ADDR_EBS_LOW, 32'h00);
      axw(ADDR_EBS_HIGH, 32'hF8);
      rd(ADDR_EBS_HIGH, 32'h08);
      chk({20'h0, erase_allow}, 32'h800);
      axw(ADDR_EBS_LOW, 32'h01);
      rd(ADDR_EBS_LOW, 32'h0);
      rd(ADDR_EBS_HIGH, 32'h0);
      axw(ADDR_EBS_LOW, 32'h10);
      @(posedge aclk) soft_write_enable <= 1'h0;
      rd(ADDR_EBS_LOW, 32'h0);
      @(posedge aclk) write_enable_pin <= 1'h0;
      axw(ADDR_EBS_LOW, 32'h02);
      rd(ADDR_EBS_LOW, 32'h0);
   endtask
   // overlay: window, block code, global protect, standby and rom-disabled behaviour
   task automatic t_overlay;
      axw(ADDR_OVL_CTRL, 32'h1B);
      @(posedge aclk) cpu_addr <= 32'h0000_3010;
      cyc(3);
      chk(mapped_addr, 32'hFFFF_A010);
      chk({31'h0, mapped_to_ram}, 32'h1);
      chk({31'h0, prog_erase_protect}, 32'h1);
      @(posedge aclk) cpu_addr <= 32'h0000_4010;
      cyc(3);
      chk(mapped_addr, 32'h0000_4010);
      axw(ADDR_OVL_CTRL, 32'h0D);
      @(posedge aclk) cpu_addr <= 32'h0000_5004;
      cyc(3);
      chk(mapped_addr, 32'hFFFF_8004);
      @(posedge aclk) sw_standby <= 1'h1;
      @(posedge aclk) sw_standby <= 1'h0;
      rd(ADDR_OVL_CTRL, 32'h0D);
      @(posedge aclk) rom_disabled <= 1'h1;
      cyc(3);
      chk({31'h0, mapped_to_ram}, 32'h0);
      @(posedge aclk) flash_error_event <= 1'h1;
      @(posedge aclk) flash_error_event <= 1'h0;
      rd(ADDR_ERR_STATUS, 32'h0);
      axw(ADDR_OVL_CTRL, 32'h1F);
      @(posedge aclk) rom_disabled <= 1'h0;
      rd(ADDR_OVL_CTRL, 32'h0D);
      rd(ADDR_ERR_STATUS, 32'h80);
      @(posedge aclk) hw_standby <= 1'h1;
      @(posedge aclk) hw_standby <= 1'h0;
      rd(ADDR_OVL_CTRL, 32'h0);
      chk({31'h0, prog_erase_protect}, 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h7);
      axw(8'h40, 32'h0, RESP_SLVERR);
      rd(8'h40, 32'h0, RESP_SLVERR);
   endtask
   // ==============================================================
   // verdict, reached from the main sequence or the watchdog
   task automatic end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog: whole run needs well under a few thousand cycles
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_error();
      t_select();
      t_overlay();
      end_of_test();
   end
endmodule
